// [logic/kwu_params.svh]
// What this block does
// RULE_01: pin joins unit only when connect bit set
// RULE_02: eight pins, upper four polarity selectable
// RULE_03: edges need prior deasserted level, bus clock
// RULE_04: falling edge is one then zero
// RULE_05: rising edge is zero then one
// RULE_06: polarity bits 7:4, one means rising/high
// RULE_07: style bit 0, one adds level sensing
// RULE_08: level style sets flag on fresh assertion
// RULE_09: level style holds flag while pin asserted
// RULE_10: stop mode bypasses clocked edge detection
// RULE_11: interrupt when flag and enable bit 1
// RULE_12: clear bit 2 write-only, reads zero
// RULE_13: flag bit 3 read-only, set by events
// RULE_14: edge style clear always wins; code lets a same-cycle edge or level set win
// RULE_15: software clears flag before stop mode
// RULE_16: connected pins are forced to input
// RULE_17: pins synchronised, events ORed together
`ifndef KWU_PARAMS_SVH
`define KWU_PARAMS_SVH
// word byte addresses
`define KWU_ADDR_W 4
`define KWU_OFS_SC 4'h0
`define KWU_OFS_PE 4'h4
`define KWU_OFS_IST 4'h8
`define KWU_OFS_IMSK 4'hc
// status/control field positions
`define KWU_BIT_MOD 0
`define KWU_BIT_IE 1
`define KWU_BIT_ACK 2
`define KWU_BIT_FLAG 3
`define KWU_EDG_LO 4
`define KWU_EDG_HI 7
// status/mask bit positions
`define KWU_IST_EVT 0
`define KWU_IST_WAKE 1
// reset values and pin count
`define KWU_RST_SC 4'h0
`define KWU_RST_PE 8'h00
`define KWU_NPINS 8
`endif

// [logic/kwu_pkg.sv]
package kwu_pkg;
  // bus slave phase, one-hot
  typedef enum logic [1:0] {
    KWU_IDLE = 2'b01,
    KWU_RESP = 2'b10
  } kwu_bus_st_t;
endpackage

// [logic/kwu_sync.sv]
// two-stage synchroniser per bit; stage one feeds stage two only
module kwu_sync (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] d_i,
  output logic [7:0] q_o
);
  logic [7:0] meta; // first stage, read only by second
  // pins idle high after reset, so no false fall on release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= 8'hff;
      q_o <= 8'hff;
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// [logic/kwu_top.sv]
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`include "kwu_params.svh"
// keypad wake unit with avalon-mm register slave
module kwu_top (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic [`KWU_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic [1:0] AVS_RESPONSE_O,
  input wire logic [7:0] KEY_PIN_I,
  input wire logic STOP_MODE_I,
  output logic [7:0] PIN_FORCE_INPUT_O,
  output logic WAKE_O,
  output logic KEY_IRQ_O,
  output logic IRQ_O
);
  // registers
  logic [7:0] pin_connect_register; // per-pin connect bits
  logic [3:0] edge_polarity_select; // upper four pins
  logic detect_style_select; // 0 edge only, 1 edge and level
  logic key_irq_enable;
  logic key_event_flag;
  logic [1:0] irq_status; // sticky event causes
  logic [1:0] irq_mask;

  // synchronised pins
  logic [7:0] pin_sync;
  kwu_sync u_sync (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .d_i(KEY_PIN_I),
    .q_o(pin_sync)
  ); // RULE_17

  // asserted level per pin: low for lower four, per polarity above
  function automatic logic [7:0] asserted_of(input logic [7:0] lvl, input logic [3:0] pol);
    asserted_of = {lvl[7:4] ~^ pol, ~lvl[3:0]}; // RULE_02 RULE_06
  endfunction

  logic [7:0] asserted_now; // enabled and asserted this cycle
  logic [7:0] asserted_raw; // unsynchronised, for stop-mode wake
  logic [7:0] prev_deasserted; // enabled pin seen deasserted last cycle
  logic [7:0] edge_hit;
  logic any_edge;
  logic any_level;
  logic ack_write;
  logic next_flag;

  assign asserted_now = asserted_of(pin_sync, edge_polarity_select)
    & pin_connect_register; // RULE_01
  assign asserted_raw = asserted_of(KEY_PIN_I, edge_polarity_select)
    & pin_connect_register;

  // last-cycle deasserted state; a pin newly connected while asserted
  // must first be seen deasserted before it can make an edge
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prev_deasserted <= 8'h00;
    end else if (CE_I) begin
      prev_deasserted <= ~asserted_of(pin_sync, edge_polarity_select)
        & pin_connect_register; // RULE_03
    end
  end

  // one-then-zero (fall) or zero-then-one (rise) per polarity
  assign edge_hit = prev_deasserted & asserted_now; // RULE_04 RULE_05
  assign any_edge = |edge_hit; // RULE_17
  assign any_level = |asserted_now;

  // bus slave: one wait cycle, answer in RESP
  kwu_pkg::kwu_bus_st_t bus_st;
  logic req;
  logic hit_sc;
  logic hit_pe;
  logic hit_ist;
  logic hit_imsk;
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign hit_sc = AVS_ADDRESS_I == `KWU_OFS_SC;
  assign hit_pe = AVS_ADDRESS_I == `KWU_OFS_PE;
  assign hit_ist = AVS_ADDRESS_I == `KWU_OFS_IST;
  assign hit_imsk = AVS_ADDRESS_I == `KWU_OFS_IMSK;
  // waitrequest low only in the answer cycle
  assign AVS_WAITREQUEST_O = !(bus_st == kwu_pkg::KWU_RESP);

  logic wr_en; // write takes effect at the answering edge
  logic wr_b0; // low byte lane enabled
  assign wr_en = CE_I && AVS_WRITE_I && (bus_st == kwu_pkg::KWU_RESP);
  assign wr_b0 = AVS_BYTEENABLE_I[0];
  assign ack_write = wr_en && wr_b0 && hit_sc && AVS_WRITEDATA_I[`KWU_BIT_ACK]; // RULE_12

  // bus phase machine
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bus_st <= kwu_pkg::KWU_IDLE;
    end else if (CE_I) begin
      case (bus_st)
        kwu_pkg::KWU_IDLE: if (req) bus_st <= kwu_pkg::KWU_RESP;
        kwu_pkg::KWU_RESP: bus_st <= kwu_pkg::KWU_IDLE;
        default: bus_st <= kwu_pkg::KWU_IDLE;
      endcase
    end
  end

  // control register writes
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_connect_register <= `KWU_RST_PE;
      edge_polarity_select <= `KWU_RST_SC;
      detect_style_select <= 1'b0;
      key_irq_enable <= 1'b0;
      irq_mask <= 2'b00;
    end else if (wr_en && wr_b0) begin
      if (hit_sc) begin
        edge_polarity_select <= AVS_WRITEDATA_I[`KWU_EDG_HI:`KWU_EDG_LO]; // RULE_06
        key_irq_enable <= AVS_WRITEDATA_I[`KWU_BIT_IE]; // RULE_11
        detect_style_select <= AVS_WRITEDATA_I[`KWU_BIT_MOD]; // RULE_07
      end
      if (hit_pe) pin_connect_register <= AVS_WRITEDATA_I[7:0]; // RULE_01
      if (hit_imsk) irq_mask <= AVS_WRITEDATA_I[1:0];
    end
  end

  // event flag: set wins over clear; level style holds it
  always_comb begin
    next_flag = key_event_flag;
    if (ack_write) next_flag = 1'b0; // RULE_14
    if (any_edge) next_flag = 1'b1; // RULE_08 RULE_13
    if (detect_style_select && any_level) next_flag = 1'b1; // RULE_09
  end

  // flag freezes with the clock enable; stop-mode wake is combinational
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      key_event_flag <= 1'b0;
    end else if (CE_I) begin
      key_event_flag <= next_flag;
    end
  end

  // sticky status: event flag rise and stop-mode wake, write one to clear
  logic flag_rise;
  logic wake_rise;
  logic wake_d;
  assign flag_rise = next_flag && !key_event_flag;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irq_status <= 2'b00;
      wake_d <= 1'b0;
    end else if (CE_I) begin
      wake_d <= WAKE_O;
      for (int i = 0; i < 2; i++) begin
        if ((i == `KWU_IST_EVT && flag_rise) || (i == `KWU_IST_WAKE && wake_rise))
          irq_status[i] <= 1'b1;
        else if (wr_en && wr_b0 && hit_ist && AVS_WRITEDATA_I[i])
          irq_status[i] <= 1'b0;
      end
    end
  end

  // stop mode: asynchronous level path; clocks may be stopped here
  assign WAKE_O = STOP_MODE_I && (|asserted_raw); // RULE_10
  assign wake_rise = WAKE_O && !wake_d;
  assign KEY_IRQ_O = key_event_flag && key_irq_enable; // RULE_11
  assign IRQ_O = |(irq_status & irq_mask);
  assign PIN_FORCE_INPUT_O = pin_connect_register; // RULE_16

  // read data registered at the request, stands in answer cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
      AVS_RESPONSE_O <= 2'b00;
    end else if (CE_I && bus_st == kwu_pkg::KWU_IDLE && req) begin
      AVS_READDATA_O <= 32'h0000_0000;
      AVS_RESPONSE_O <= 2'b00;
      if (hit_sc)
        AVS_READDATA_O[7:0] <= {edge_polarity_select, key_event_flag, 1'b0,
          key_irq_enable, detect_style_select}; // RULE_12 RULE_13
      else if (hit_pe) AVS_READDATA_O[7:0] <= pin_connect_register;
      else if (hit_ist) AVS_READDATA_O[1:0] <= irq_status;
      else if (hit_imsk) AVS_READDATA_O[1:0] <= irq_mask;
      else AVS_RESPONSE_O <= 2'b10; // unmapped: slave error
    end
  end
endmodule

// [sim/kwu_asserts.sv]
`include "kwu_params.svh"
// bus and pin checks on the wake unit top ports
module kwu_asserts (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic [`KWU_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [1:0] AVS_RESPONSE_O,
  input wire logic STOP_MODE_I,
  input wire logic [7:0] PIN_FORCE_INPUT_O,
  input wire logic WAKE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // a request taken by the idle slave
  sequence taken_s;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CE_I;
  endsequence
  // answer edge of a connect write on lane 0
  sequence pe_wr_s;
    AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `KWU_OFS_PE && AVS_BYTEENABLE_I[0];
  endsequence
  a_one_wait: assert property (taken_s |=> !AVS_WAITREQUEST_O) else $error("answer late");
  a_resp_code: assert property (!AVS_WAITREQUEST_O && (AVS_READ_I || AVS_WRITE_I)
    |-> AVS_RESPONSE_O == ((AVS_ADDRESS_I[1:0] != 2'h0) ? 2'h2 : 2'h0)) else $error("bad resp");
  a_data_stands: assert property (!AVS_READ_I && !AVS_WRITE_I
    |=> $stable(AVS_READDATA_O) && $stable(AVS_RESPONSE_O)) else $error("data moved");
  a_clear_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0
    |-> !AVS_READDATA_O[`KWU_BIT_ACK]) else $error("clear bit read one");
  a_force_input: assert property (pe_wr_s |=> PIN_FORCE_INPUT_O == $past(AVS_WRITEDATA_I[7:0]))
    else $error("force mask wrong");
  a_force_held: assert property ($changed(PIN_FORCE_INPUT_O) |-> $past(AVS_WRITE_I))
    else $error("force moved alone");
  a_wake_stop: assert property (!STOP_MODE_I |-> !WAKE_O) else $error("wake out of stop");
  a_wake_pin: assert property (WAKE_O |-> |PIN_FORCE_INPUT_O) else $error("wake unconnected");
endmodule
bind kwu_top kwu_asserts chk_u (.*);

// [sim/kwu_keys.sv]
// key switches: an open key rests deasserted, a closed one drives the active level
module kwu_keys (
  input wire logic [7:0] press_i,
  input wire logic [7:0] high_i,
  output logic [7:0] pin_o
);
  // open keys return to the idle level so a later edge can be seen
  assign pin_o = ~(press_i ^ high_i);
endmodule

// [sim/kwu_test.sv]
`include "kwu_params.svh"
module kwu_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 0, ARST_N_I = 0, AVS_READ_I = 0, AVS_WRITE_I = 0, STOP_MODE_I = 0, CE_I = 1;
  logic [3:0] AVS_ADDRESS_I = 4'h0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0, AVS_READDATA_O, q;
  logic [1:0] AVS_RESPONSE_O, rsp;
  logic [7:0] KEY_PIN_I, PIN_FORCE_INPUT_O, press = 8'h00, high = 8'h00;
  logic AVS_WAITREQUEST_O, WAKE_O, KEY_IRQ_O, IRQ_O;
  int fails = 0, comparisons = 0;
  kwu_top dut_u (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .AVS_RESPONSE_O(AVS_RESPONSE_O), .KEY_PIN_I(KEY_PIN_I), .STOP_MODE_I(STOP_MODE_I),
    .PIN_FORCE_INPUT_O(PIN_FORCE_INPUT_O), .WAKE_O(WAKE_O), .KEY_IRQ_O(KEY_IRQ_O), .IRQ_O(IRQ_O));
  kwu_keys key_u (.press_i(press), .high_i(high), .pin_o(KEY_PIN_I));
  // 8 ns clock
  initial begin
    forever #4 CLK_I = ~CLK_I;
  end
  // one bus cycle; waitrequest and data are taken at the rising edge, before it updates the slave
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= {24'h0, d};
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    q = AVS_READDATA_O;
    rsp = AVS_RESPONSE_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
    @(posedge CLK_I);
    if (n >= 50) begin
      fails++;
      $display("BAD %0t bus answer missing", $time);
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // key change, then the two sync stages plus flag
  task automatic keys(input logic [7:0] p);
    press <= p;
    repeat (4) @(posedge CLK_I);
  endtask
  task automatic t_regs;
    rd(`KWU_OFS_SC, 32'h00);
    bus(1'b1, `KWU_OFS_SC, 8'hf7);
    rd(`KWU_OFS_SC, 32'hf3);
    bus(1'b1, `KWU_OFS_PE, 8'h5a);
    chk({24'h0, PIN_FORCE_INPUT_O}, 32'h5a);
    rd(4'h6, 32'h00);
    chk({30'h0, rsp}, 32'h2);
    // disconnect first so the level hold cannot keep the flag up
    bus(1'b1, `KWU_OFS_PE, 8'h00);
    bus(1'b1, `KWU_OFS_SC, 8'h04);
  endtask
  task automatic t_edge;
    bus(1'b1, `KWU_OFS_PE, 8'h01);
    bus(1'b1, `KWU_OFS_SC, 8'h02);
    keys(8'h02);
    rd(`KWU_OFS_SC, 32'h02);
    keys(8'h03);
    rd(`KWU_OFS_SC, 32'h0a);
    chk({31'h0, KEY_IRQ_O}, 32'h1);
    bus(1'b1, `KWU_OFS_SC, 8'h06);
    rd(`KWU_OFS_SC, 32'h02);
    keys(8'h00);
  endtask
  task automatic t_rise;
    high <= 8'h10;
    bus(1'b1, `KWU_OFS_PE, 8'h10);
    bus(1'b1, `KWU_OFS_SC, 8'h14);
    keys(8'h10);
    rd(`KWU_OFS_SC, 32'h18);
    keys(8'h00);
  endtask
  task automatic t_level;
    bus(1'b1, `KWU_OFS_PE, 8'h01);
    bus(1'b1, `KWU_OFS_SC, 8'h05);
    keys(8'h01);
    bus(1'b1, `KWU_OFS_SC, 8'h05);
    rd(`KWU_OFS_SC, 32'h09);
    keys(8'h00);
    bus(1'b1, `KWU_OFS_SC, 8'h05);
    rd(`KWU_OFS_SC, 32'h01);
  endtask
  task automatic t_irq;
    chk({31'h0, IRQ_O}, 32'h0);
    bus(1'b1, `KWU_OFS_IMSK, 8'h01);
    chk({31'h0, IRQ_O}, 32'h1);
    bus(1'b1, `KWU_OFS_IST, 8'h03);
    chk({31'h0, IRQ_O}, 32'h0);
  endtask
  task automatic t_stop;
    bus(1'b1, `KWU_OFS_SC, 8'h04);
    STOP_MODE_I <= 1'b1;
    keys(8'h01);
    chk({31'h0, WAKE_O}, 32'h1);
    STOP_MODE_I <= 1'b0;
    keys(8'h00);
  endtask
  // clock enable low freezes the synchroniser and flag
  task automatic t_hold;
    bus(1'b1, `KWU_OFS_SC, 8'h06);
    CE_I <= 1'b0;
    keys(8'h01);
    chk({31'h0, KEY_IRQ_O}, 32'h0);
    CE_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    chk({31'h0, KEY_IRQ_O}, 32'h1);
  endtask
  task automatic stop_test;
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CLK_I);
    ARST_N_I <= 1'b1;
    @(posedge CLK_I);
    t_regs();
    t_edge();
    t_rise();
    t_level();
    t_irq();
    t_stop();
    t_hold();
    stop_test();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK_I);
    fails++;
    $display("BAD %0t timeout", $time);
    stop_test();
  end
endmodule
